// ### rtl/rpg_pkg.sv
// constants and types for the rate-limited pattern generator and checker
package rpg_pkg;

	localparam int RPG_WORD_W = 256;
	localparam int RPG_DW_PER_WORD = 8;
	localparam int RPG_WORDS_PER_SEG = 16; // 512 bytes of 32-byte words
	localparam int RPG_SEG_IDX_W = 4;
	localparam int RPG_ADDR_W = 48;
	localparam int RPG_LEN_W = 32;
	localparam int RPG_RATE_W = 7;
	localparam logic [6:0] RPG_WINDOW = 7'h64; // 100 cycles
	localparam logic [6:0] RPG_SLOT_FIRST = 7'h01;
	localparam int RPG_RD_LAT = 2;

	// lfsr seed constant mixed into the seed built from the upper half of the low address dword
	localparam logic [31:0] RPG_SEED_HI_MIX = 32'h0000_ffff;

	typedef enum logic [2:0] {
		RPG_PAT_INC = 3'h0,
		RPG_PAT_DEC = 3'h1,
		RPG_PAT_LFSR = 3'h2,
		RPG_PAT_ZERO = 3'h3,
		RPG_PAT_ONE = 3'h4
	} rpg_pattern_t;

	typedef enum logic [2:0] {
		RPG_ST_IDLE = 3'b001,
		RPG_ST_WRITE = 3'b010,
		RPG_ST_READ = 3'b100
	} rpg_state_t;

endpackage

// ### rtl/rpg_top.sv
// rate-limited 256-bit pattern generator and checker for one user port
`timescale 1ns/1ps

module rpg_top #(
	parameter int LEN_W = rpg_pkg::RPG_LEN_W
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	input wire logic WRITE_BEGIN_PULSE_I,
	input wire logic READ_BEGIN_PULSE_I,
	input wire logic [LEN_W-1:0] TRANSFER_LENGTH_I,
	input wire logic [rpg_pkg::RPG_ADDR_W-1:0] START_BLOCK_ADDRESS_I,
	input wire logic [2:0] PATTERN_CHOICE_I,
	input wire logic [6:0] RATE_PERCENT_I,
	input wire logic CHECK_ENABLE_I,
	input wire logic [rpg_pkg::RPG_ADDR_W-1:0] HEADER_QUEUE_I,
	output logic HEADER_QUEUE_POP_O,
	input wire logic TX_FIFO_ALMOST_FULL_I,
	output logic TX_FIFO_PUSH_O,
	output logic [rpg_pkg::RPG_WORD_W-1:0] TX_FIFO_WORD_O,
	input wire logic RX_FIFO_EMPTY_I,
	output logic RX_FIFO_POP_O,
	input wire logic [rpg_pkg::RPG_WORD_W-1:0] RX_FIFO_WORD_I,
	output logic WRITE_ACTIVE_O,
	output logic READ_ACTIVE_O,
	output logic COMPARE_ERROR_O,
	output logic [LEN_W-1:0] BEAT_COUNTER_O
);

	initial begin
		if (LEN_W < 2 || LEN_W > 48) begin
			$error("rpg_top: LEN_W out of range");
		end
	end

	// ----------------------------------------------------------------
	// state and counters
	// ----------------------------------------------------------------
	rpg_pkg::rpg_state_t state;
	rpg_pkg::rpg_state_t next_state;
	logic [6:0] rate_slot_count;
	logic rate_slot_enable;
	logic [LEN_W-1:0] beat_counter;
	logic [LEN_W-1:0] end_count;
	logic [rpg_pkg::RPG_SEG_IDX_W-1:0] seg_idx;
	logic [31:0] data_count;
	logic [127:0] lfsr_a;
	logic [127:0] lfsr_b;
	logic [rpg_pkg::RPG_WORD_W-1:0] gen_word;
	logic [rpg_pkg::RPG_ADDR_W-1:0] header;
	logic [rpg_pkg::RPG_RD_LAT-1:0] pop_pipe;
	logic compare_error;

	wire write_active = (state == rpg_pkg::RPG_ST_WRITE);
	wire read_active = (state == rpg_pkg::RPG_ST_READ);
	wire any_active = write_active | read_active;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	// the last beat drops push one cycle before write_active falls
	wire write_done = write_active && (beat_counter == end_count);
	wire read_done = read_active && (beat_counter == end_count);
	// push and pop need slot, room or data, and an open transfer
	wire push = write_active && !write_done && rate_slot_enable && !TX_FIFO_ALMOST_FULL_I;
	// pop is gated by the slot flop directly, so it falls with it
	wire pop = read_active && rate_slot_enable && !RX_FIFO_EMPTY_I;
	wire read_beat = pop_pipe[rpg_pkg::RPG_RD_LAT-1];
	wire gen_step = push | read_beat;
	wire seg_start = (seg_idx == '0);
	wire seg_last = (seg_idx == rpg_pkg::RPG_SEG_IDX_W'(rpg_pkg::RPG_WORDS_PER_SEG - 1));
	wire [2:0] pat = PATTERN_CHOICE_I;
	wire hdr_pattern = (pat == rpg_pkg::RPG_PAT_INC) || (pat == rpg_pkg::RPG_PAT_DEC)
		|| (pat == rpg_pkg::RPG_PAT_LFSR);
	wire [31:0] addr_low = START_BLOCK_ADDRESS_I[31:0];
	wire [31:0] addr_low_inv = ~addr_low;
	wire [LEN_W-1:0] next_end = TRANSFER_LENGTH_I;

	// ----------------------------------------------------------------
	// state machine
	// ----------------------------------------------------------------
	// begin pulses are taken only from idle; a pulse while busy is dropped
	always_comb begin
		next_state = state;
		case (state)
			rpg_pkg::RPG_ST_IDLE: begin
				if (WRITE_BEGIN_PULSE_I) begin
					next_state = rpg_pkg::RPG_ST_WRITE;
				end else if (READ_BEGIN_PULSE_I) begin
					next_state = rpg_pkg::RPG_ST_READ;
				end
			end
			rpg_pkg::RPG_ST_WRITE: begin
				if (write_done) begin
					next_state = rpg_pkg::RPG_ST_IDLE;
				end
			end
			rpg_pkg::RPG_ST_READ: begin
				if (read_done) begin
					next_state = rpg_pkg::RPG_ST_IDLE;
				end
			end
			default: next_state = rpg_pkg::RPG_ST_IDLE;
		endcase
	end

	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			state <= rpg_pkg::RPG_ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------------------------------
	// rate throttle
	// ----------------------------------------------------------------
	// count reloaded to the window value while idle so a new transfer opens a fresh window
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			rate_slot_count <= rpg_pkg::RPG_WINDOW;
			rate_slot_enable <= 1'b0;
		end else if (any_active) begin
			if (rate_slot_count == rpg_pkg::RPG_WINDOW) begin
				rate_slot_count <= rpg_pkg::RPG_SLOT_FIRST;
			end else begin
				rate_slot_count <= rate_slot_count + 7'h01;
			end
			// on at 100, off at rate_percent: rate_percent cycles per window
			if (rate_slot_count == rpg_pkg::RPG_WINDOW && RATE_PERCENT_I != 7'h00) begin
				rate_slot_enable <= 1'b1;
			end else if (rate_slot_count == RATE_PERCENT_I) begin
				rate_slot_enable <= 1'b0;
			end
		end else begin
			rate_slot_count <= rpg_pkg::RPG_WINDOW;
			rate_slot_enable <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// beat counter, end size and read latency pipe
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			beat_counter <= '0;
			end_count <= '0;
			pop_pipe <= '0;
		end else begin
			pop_pipe <= {pop_pipe[rpg_pkg::RPG_RD_LAT-2:0], pop};
			if (state == rpg_pkg::RPG_ST_IDLE && (WRITE_BEGIN_PULSE_I || READ_BEGIN_PULSE_I)) begin
				beat_counter <= '0;
				end_count <= next_end;
			end else if (push) begin
				beat_counter <= beat_counter + 1'b1;
			end else if (read_active && read_beat) begin
				beat_counter <= beat_counter + 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// lfsr look-ahead
	// ----------------------------------------------------------------
	// one step of x^32 + x^22 + x^2 + x + 1 on a 32-bit fibonacci register
	function automatic logic [31:0] lfsr_step(input logic [31:0] v);
		logic fb;
		fb = v[31] ^ v[21] ^ v[1] ^ v[0];
		lfsr_step = {v[30:0], fb};
	endfunction

	// four successive values per half, newest in the top dword
	function automatic logic [127:0] lfsr_adv(input logic [127:0] h);
		logic [31:0] v0;
		logic [31:0] v1;
		logic [31:0] v2;
		logic [31:0] v3;
		v0 = lfsr_step(h[127:96]);
		v1 = lfsr_step(v0);
		v2 = lfsr_step(v1);
		v3 = lfsr_step(v2);
		lfsr_adv = {v3, v2, v1, v0};
	endfunction

	// distinct seeds from address halves and their inverse
	wire [31:0] seed_a = {addr_low[15:0], addr_low_inv[15:0]};
	wire [31:0] seed_b = {addr_low_inv[31:16], addr_low[31:16]} ^ rpg_pkg::RPG_SEED_HI_MIX;
	wire [127:0] lfsr_a_init = lfsr_adv({seed_a, 96'h0});
	wire [127:0] lfsr_b_init = lfsr_adv({seed_b, 96'h0});

	// ----------------------------------------------------------------
	// pattern state
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			seg_idx <= '0;
			data_count <= '0;
			lfsr_a <= '0;
			lfsr_b <= '0;
			header <= '0;
		end else if (state == rpg_pkg::RPG_ST_IDLE) begin
			seg_idx <= '0;
			data_count <= '0;
			lfsr_a <= lfsr_a_init;
			lfsr_b <= lfsr_b_init;
			header <= HEADER_QUEUE_I;
		end else if (gen_step) begin
			seg_idx <= seg_last ? '0 : seg_idx + 1'b1;
			data_count <= data_count + 32'h0000_0008;
			lfsr_a <= lfsr_adv(lfsr_a);
			lfsr_b <= lfsr_adv(lfsr_b);
			if (seg_last) begin
				header <= HEADER_QUEUE_I;
			end
		end
	end

	// next segment address is taken when the current one closes
	assign HEADER_QUEUE_POP_O = gen_step && seg_last && hdr_pattern;

	// ----------------------------------------------------------------
	// word assembly
	// ----------------------------------------------------------------
	always_comb begin
		gen_word = '0;
		for (int i = 0; i < rpg_pkg::RPG_DW_PER_WORD; i++) begin
			case (pat)
				rpg_pkg::RPG_PAT_INC: gen_word[i*32 +: 32] = data_count + 32'(i);
				rpg_pkg::RPG_PAT_DEC: gen_word[i*32 +: 32] = ~(data_count + 32'(i));
				rpg_pkg::RPG_PAT_LFSR: gen_word[i*32 +: 32] = (i < 4) ? lfsr_a[i*32 +: 32]
					: lfsr_b[(i-4)*32 +: 32];
				rpg_pkg::RPG_PAT_ONE: gen_word[i*32 +: 32] = 32'hffff_ffff;
				default: gen_word[i*32 +: 32] = 32'h0000_0000;
			endcase
		end
		// header replaces dwords 0 and 1 of the first word in a segment
		if (seg_start && hdr_pattern) begin
			gen_word[63:0] = {16'h0000, header};
		end
	end

	// ----------------------------------------------------------------
	// write data and checking
	// ----------------------------------------------------------------
	// data registered with push so both leave the block together
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			TX_FIFO_PUSH_O <= 1'b0;
			TX_FIFO_WORD_O <= '0;
		end else begin
			TX_FIFO_PUSH_O <= push;
			if (push) begin
				TX_FIFO_WORD_O <= gen_word;
			end
		end
	end

	// sticky error, cleared only by the next read begin
	always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
		if (RST_I) begin
			compare_error <= 1'b0;
		end else if (read_active && read_beat && CHECK_ENABLE_I
			&& RX_FIFO_WORD_I != gen_word) begin
			compare_error <= 1'b1;
		end else if (state == rpg_pkg::RPG_ST_IDLE && READ_BEGIN_PULSE_I
			&& !WRITE_BEGIN_PULSE_I) begin
			compare_error <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign RX_FIFO_POP_O = pop;
	assign WRITE_ACTIVE_O = write_active;
	assign READ_ACTIVE_O = read_active;
	assign COMPARE_ERROR_O = compare_error;
	assign BEAT_COUNTER_O = beat_counter;

endmodule

// ### bench/rpg_props.sv
// port assertions for the rate-limited pattern generator
`timescale 1ns/1ps
module rpg_props #(
	parameter int LEN_W = 32
) (
	input wire logic CLK_SYS_I,
	input wire logic RST_I,
	input wire logic WRITE_BEGIN_PULSE_I,
	input wire logic READ_BEGIN_PULSE_I,
	input wire logic [LEN_W-1:0] TRANSFER_LENGTH_I,
	input wire logic TX_FIFO_ALMOST_FULL_I,
	input wire logic TX_FIFO_PUSH_O,
	input wire logic RX_FIFO_EMPTY_I,
	input wire logic RX_FIFO_POP_O,
	input wire logic WRITE_ACTIVE_O,
	input wire logic READ_ACTIVE_O,
	input wire logic COMPARE_ERROR_O,
	input wire logic [LEN_W-1:0] BEAT_COUNTER_O
);
	// ----------
	// properties
	// ----------
	wire idle = !WRITE_ACTIVE_O && !READ_ACTIVE_O;
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (RST_I);
	sequence s_wr_take; idle && WRITE_BEGIN_PULSE_I; endsequence
	sequence s_rd_take; idle && READ_BEGIN_PULSE_I && !WRITE_BEGIN_PULSE_I; endsequence
	property p_wr_start; s_wr_take |=> WRITE_ACTIVE_O; endproperty
	a_wr_start: assert property (p_wr_start) else $error("write not started");
	property p_rd_start; s_rd_take |=> READ_ACTIVE_O; endproperty
	a_rd_start: assert property (p_rd_start) else $error("read not started");
	property p_push_ok; TX_FIFO_PUSH_O |-> $past(WRITE_ACTIVE_O) && !$past(TX_FIFO_ALMOST_FULL_I); endproperty
	a_push_ok: assert property (p_push_ok) else $error("push without room");
	property p_pop_ok; RX_FIFO_POP_O |-> READ_ACTIVE_O && !RX_FIFO_EMPTY_I; endproperty
	a_pop_ok: assert property (p_pop_ok) else $error("pop without data");
	property p_wr_beat; TX_FIFO_PUSH_O |-> BEAT_COUNTER_O == $past(BEAT_COUNTER_O) + 1'b1; endproperty
	a_wr_beat: assert property (p_wr_beat) else $error("write beat miscount");
	// read data lands two cycles after the pop, the count one edge later
	property p_rd_beat; RX_FIFO_POP_O |-> ##3 BEAT_COUNTER_O == $past(BEAT_COUNTER_O) + 1'b1; endproperty
	a_rd_beat: assert property (p_rd_beat) else $error("read beat miscount");
	property p_wr_end; $fell(WRITE_ACTIVE_O) |-> !TX_FIFO_PUSH_O && BEAT_COUNTER_O == TRANSFER_LENGTH_I; endproperty
	a_wr_end: assert property (p_wr_end) else $error("write end wrong");
	property p_rd_end; $fell(READ_ACTIVE_O) |-> BEAT_COUNTER_O == TRANSFER_LENGTH_I; endproperty
	a_rd_end: assert property (p_rd_end) else $error("read end wrong");
	property p_err_hold; COMPARE_ERROR_O && !(idle && READ_BEGIN_PULSE_I) |=> COMPARE_ERROR_O; endproperty
	a_err_hold: assert property (p_err_hold) else $error("error flag lost");
endmodule
bind rpg_top rpg_props #(.LEN_W(LEN_W)) u_rpg_props (.CLK_SYS_I, .RST_I, .WRITE_BEGIN_PULSE_I,
	.READ_BEGIN_PULSE_I, .TRANSFER_LENGTH_I, .TX_FIFO_ALMOST_FULL_I, .TX_FIFO_PUSH_O,
	.RX_FIFO_EMPTY_I, .RX_FIFO_POP_O, .WRITE_ACTIVE_O, .READ_ACTIVE_O, .COMPARE_ERROR_O,
	.BEAT_COUNTER_O);

// ### bench/rpg_fifo_model.sv
// far-side fifo pair: logs pushed words, serves loaded words two cycles after a pop
`timescale 1ns/1ps
module rpg_fifo_model (
	input wire logic clk_i,
	input wire logic stall_i,
	input wire logic push_i,
	input wire logic [255:0] push_word_i,
	input wire logic pop_i,
	output logic almost_full_o,
	output logic empty_o,
	output logic [255:0] pop_word_o
);
	logic [255:0] rxq[$];
	logic [255:0] txq[$];
	int push_cyc[$];
	int cyc = 0;
	int rx_n = 0;
	logic [255:0] stage = '0;
	logic stage_vld = 1'b0;
	// stall throttles both directions at once
	assign almost_full_o = stall_i;
	assign empty_o = stall_i || rx_n == 0;
	task automatic load(input logic [255:0] w);
		rxq.push_back(w);
		rx_n++;
	endtask
	// idle data line toggles so a late sample never matches by luck
	always @(posedge clk_i) begin
		cyc++;
		if (push_i) begin
			txq.push_back(push_word_i);
			push_cyc.push_back(cyc);
		end
		pop_word_o <= stage_vld ? stage : ~pop_word_o;
		stage_vld <= pop_i && !empty_o;
		if (pop_i && !empty_o) begin
			stage <= rxq.pop_front();
			rx_n--;
		end
	end
	initial pop_word_o = '0;
endmodule

// ### bench/test_rate_limited_pattern_gen_check.sv
// self-checking bench for the rate-limited pattern generator and checker
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
	$display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
module test_rate_limited_pattern_gen_check;
	localparam logic [47:0] HDR = 48'h0a1b_2c3d_4e5f;
	logic clk, rst, wr_go, rd_go, chk_en, stall, stall_en, afull, push, empty, pop;
	logic wr_act, rd_act, err;
	logic [31:0] len, beat;
	logic [2:0] pat;
	logic [6:0] rate;
	logic [255:0] txw, rxw;
	logic [2:0] pl[5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
	int fails = 0;
	int total_checks = 0;
	rpg_top u_rpg_top (.CLK_SYS_I(clk), .RST_I(rst), .WRITE_BEGIN_PULSE_I(wr_go),
		.READ_BEGIN_PULSE_I(rd_go), .TRANSFER_LENGTH_I(len), .START_BLOCK_ADDRESS_I(48'h1234_5678_9abc),
		.PATTERN_CHOICE_I(pat), .RATE_PERCENT_I(rate), .CHECK_ENABLE_I(chk_en), .HEADER_QUEUE_I(HDR),
		.HEADER_QUEUE_POP_O(), .TX_FIFO_ALMOST_FULL_I(afull), .TX_FIFO_PUSH_O(push),
		.TX_FIFO_WORD_O(txw), .RX_FIFO_EMPTY_I(empty), .RX_FIFO_POP_O(pop), .RX_FIFO_WORD_I(rxw),
		.WRITE_ACTIVE_O(wr_act), .READ_ACTIVE_O(rd_act), .COMPARE_ERROR_O(err), .BEAT_COUNTER_O(beat));
	rpg_fifo_model u_rpg_fifo_model (.clk_i(clk), .stall_i(stall), .push_i(push), .push_word_i(txw),
		.pop_i(pop), .almost_full_o(afull), .empty_o(empty), .pop_word_o(rxw));
	// ------------
	// helpers
	// ------------
	function automatic logic [255:0] exp_word(input logic [2:0] p, input int k);
		logic [255:0] w;
		for (int i = 0; i < 8; i++) w[32*i +: 32] = 32'(8 * k + i);
		if (p == 3'h1) w = ~w;
		if (p > 3'h2) w = {256{p == 3'h4}};
		if (p < 3'h3 && k % 16 == 0) w[63:0] = {16'h0, HDR};
		return w;
	endfunction
	task automatic run(input logic wr, input logic [2:0] p, input int n, input logic [6:0] r);
		int t;
		@(posedge clk);
		pat <= p;
		len <= 32'(n);
		rate <= r;
		wr_go <= wr;
		rd_go <= !wr;
		@(posedge clk);
		wr_go <= 1'b0;
		rd_go <= 1'b0;
		t = 0;
		@(posedge clk);
		while ((wr_act || rd_act) && t < 20000) begin @(posedge clk); t++; end
		`CHK(t < 20000, 1'b1)
		`CHK(beat, 32'(n))
	endtask
	task automatic conclude();
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// ------------
	// clock, stall, watchdog
	// ------------
	initial begin clk = 1'b0; forever #4 clk = ~clk; end
	always @(posedge clk) stall <= stall_en && u_rpg_fifo_model.cyc % 13 > 9;
	initial begin #800000; fails++; conclude(); end
	// ------------
	// tests
	// ------------
	initial begin
		{rst, wr_go, rd_go, chk_en, stall, stall_en} = 6'h21;
		{len, pat, rate} = '0;
		repeat (3) @(posedge clk);
		`CHK({wr_act, rd_act, push, pop, err, beat}, 37'h0)
		rst <= 1'b0;
		stall_en = 1'b1;
		foreach (pl[j]) begin
			u_rpg_fifo_model.txq.delete();
			run(1'b1, pl[j], 20, 7'h64);
			`CHK(u_rpg_fifo_model.txq.size(), 20)
			for (int k = 0; k < 20; k++) `CHK(u_rpg_fifo_model.txq[k], exp_word(pl[j], k))
		end
		stall_en = 1'b0;
		u_rpg_fifo_model.push_cyc.delete();
		run(1'b1, 3'h0, 50, 7'h28);
		`CHK(u_rpg_fifo_model.push_cyc[39] - u_rpg_fifo_model.push_cyc[0], 39)
		`CHK(u_rpg_fifo_model.push_cyc[40] - u_rpg_fifo_model.push_cyc[0], 100)
		stall_en = 1'b1;
		u_rpg_fifo_model.txq.delete();
		run(1'b1, 3'h2, 20, 7'h64);
		`CHK(u_rpg_fifo_model.txq[16][63:0], {16'h0, HDR})
		chk_en <= 1'b1;
		for (int e = 0; e < 3; e++) begin
			foreach (u_rpg_fifo_model.txq[k]) u_rpg_fifo_model.load(u_rpg_fifo_model.txq[k] ^ 256'(e == 1 && k == 5));
			run(1'b0, 3'h2, 20, 7'h64);
			repeat (4) @(posedge clk);
			`CHK(err, e == 1)
		end
		conclude();
	end
endmodule
